// [design/uat_translator.sv]
`timescale 1ns/1ps
// Behaviour
// - one entry per 2K page, access plus page
// - four user and four channel tables
// - user entry: write lock, logical, physical page
// - channel entry invalid when flag and page ones
// - lef mode turns io instructions into lef
// - failed checks raise a protection fault
// - user off: page 31 uses page31 register
// - control write copies into status and pagecheck
// - bits 0 and 13 pick next user table
// - bits 6-8 pick bulk load target table
// - lef bit only with user enable
// - bits 10-12 enable io, write, indirect protection
// - bit 14 enables channel translation at once
// - user enable waits for indirect, holds interrupts
// - bulk load fills selected table at each word's logical page
// - processor supplies count and resolved pointer
// - count down, pointer up, other accumulators untouched
// - bus reset drops user, clears status bits except bit 15
// - probe select then probe read returns entry
// - p function: single reference or user off
// - user b reads back as 01
// - page31 register resets to all ones
module uat_translator (
   input  wire logic                      i_core_clk,
   input  wire logic                      i_reset_n,
   input  wire logic                      i_io_valid,
   input  wire logic [5:0]                i_io_dev,
   input  wire uat_pkg::uat_op_t          i_io_op,
   input  wire logic [uat_pkg::WORD_W-1:0] i_io_data,
   input  wire logic                      i_ref_valid,
   input  wire uat_pkg::uat_ref_t         i_ref,
   input  wire logic                      i_int_taken,
   input  wire logic                      i_lmp_start,
   input  wire logic [uat_pkg::WORD_W-1:0] i_count_acc,
   input  wire logic [uat_pkg::WORD_W-1:0] i_pointer_acc,
   input  wire logic                      i_mem_valid,
   input  wire logic [uat_pkg::WORD_W-1:0] i_mem_data,
   output logic [uat_pkg::WORD_W-1:0]     o_rd_data,
   output logic                           o_rd_valid,
   output logic [uat_pkg::PHYS_W-1:0]     o_phys_addr,
   output logic                           o_xlate_done,
   output logic                           o_fault,
   output logic                           o_lef_exec,
   output logic                           o_int_hold,
   output logic                           o_mem_req,
   output logic [uat_pkg::WORD_W-1:0]     o_mem_addr,
   output logic [uat_pkg::WORD_W-1:0]     o_count_acc,
   output logic                           o_load_busy
);
   logic [uat_pkg::WORD_W-1:0] tables [uat_pkg::NTBL][uat_pkg::NENT];
   logic [uat_pkg::WORD_W-1:0] st, next_st, pchk, next_pchk;
   logic [uat_pkg::PAGE_W-1:0] p31, next_p31;
   logic usr_pend, next_usr_pend, single, next_single;
   logic [uat_pkg::WORD_W-1:0] next_rd;
   logic next_rdv, next_fault, next_lef, next_done;
   logic [uat_pkg::PHYS_W-1:0] next_phys;
   uat_pkg::uat_ld_t ld, next_ld;
   logic [uat_pkg::WORD_W-1:0] next_cnt, ptr, next_ptr;
   logic next_mreq, tbl_we;
   logic [2:0] ref_tbl;
   logic [uat_pkg::WORD_W-1:0] ent, pent;
   logic cmd_hit, user_act;

   // table code: A=000, C=001, B=010, D=011 (channel tables set the top bit)
   function automatic logic [2:0] tbl_code(input logic chan, input logic hi, input logic lo);
      return {chan, lo, hi};
   endfunction

   assign cmd_hit  = i_io_valid && (i_io_dev == uat_pkg::DEV_CODE);
   assign user_act = st[uat_pkg::B_USR_ST] | single;
   assign ref_tbl  = i_ref.chan ? tbl_code(1'b1, i_ref.chan_tbl[1], i_ref.chan_tbl[0])
                   : tbl_code(1'b0, st[uat_pkg::B_MTE_HI], st[uat_pkg::B_MTE_LO]);
   assign ent  = tables[ref_tbl][i_ref.addr[uat_pkg::WORD_W-1 -: uat_pkg::LPAGE_W]];
   assign pent = tables[pchk[uat_pkg::SEL_LSB +: 3]][pchk[uat_pkg::LPG_LSB +: uat_pkg::LPAGE_W]];

   always_comb begin
      next_st       = st;
      next_pchk     = pchk;
      next_p31      = p31;
      next_usr_pend = usr_pend;
      next_single   = single;
      next_rd       = o_rd_data;
      next_rdv      = 1'b0;
      next_phys     = o_phys_addr;
      next_fault    = 1'b0;
      next_lef      = 1'b0;
      next_done     = 1'b0;
      if (i_int_taken) begin
         next_st[uat_pkg::B_UI] = st[uat_pkg::B_USR_ST];
      end
      if (i_ref_valid) begin
         next_done = 1'b1;
         next_phys = {{uat_pkg::PHYS_W-uat_pkg::WORD_W{1'b0}}, i_ref.addr};
         if (i_ref.chan) begin
            if (st[uat_pkg::B_DCH]) begin
               next_phys = {ent[uat_pkg::PAGE_W-1:0], i_ref.addr[uat_pkg::OFS_W-1:0]};
               next_fault = ent[uat_pkg::B_FLAG] && (&ent[uat_pkg::PAGE_W-1:0]);
            end
         end else if (user_act) begin
            next_phys = {ent[uat_pkg::PAGE_W-1:0], i_ref.addr[uat_pkg::OFS_W-1:0]};
            next_lef  = i_ref.io_instr && st[uat_pkg::B_LEF];
            next_st[uat_pkg::B_IOF] = i_ref.io_instr && st[uat_pkg::B_IO]
                                      && !st[uat_pkg::B_LEF];
            next_st[uat_pkg::B_WPF] = i_ref.write && st[uat_pkg::B_WP]
                                      && ent[uat_pkg::B_FLAG];
            next_st[uat_pkg::B_IDF] = i_ref.indirect && st[uat_pkg::B_IN];
            next_fault = next_st[uat_pkg::B_IOF] | next_st[uat_pkg::B_WPF]
                       | next_st[uat_pkg::B_IDF];
            if (next_fault) begin
               next_st[uat_pkg::B_SC] = single;
            end else begin
               next_st[uat_pkg::B_IOF] = st[uat_pkg::B_IOF];
               next_st[uat_pkg::B_WPF] = st[uat_pkg::B_WPF];
               next_st[uat_pkg::B_IDF] = st[uat_pkg::B_IDF];
            end
            next_single = 1'b0;
         end else if (i_ref.addr[uat_pkg::WORD_W-1 -: uat_pkg::LPAGE_W] == uat_pkg::PAGE31) begin
            next_phys = {p31, i_ref.addr[uat_pkg::OFS_W-1:0]};
         end
         // the reference after the indirect one is the first translated one
         if (usr_pend && i_ref.indirect) begin
            next_usr_pend = 1'b0;
            next_st[uat_pkg::B_USR_ST] = 1'b1;
         end
      end
      if (cmd_hit) begin
         unique case (i_io_op)
            uat_pkg::UAT_OP_WRITE_CONTROL: begin
               next_st[uat_pkg::B_MTE_HI]             = i_io_data[uat_pkg::B_MTE_HI];
               next_st[uat_pkg::B_MTE_LO]             = i_io_data[uat_pkg::B_MTE_LO];
               next_st[uat_pkg::SEL_LSB +: 3]         = i_io_data[uat_pkg::SEL_LSB +: 3];
               next_st[uat_pkg::B_LEF]                = i_io_data[uat_pkg::B_LEF]
                                                        && i_io_data[uat_pkg::B_USR];
               next_st[uat_pkg::B_IO]                 = i_io_data[uat_pkg::B_IO];
               next_st[uat_pkg::B_WP]                 = i_io_data[uat_pkg::B_WP];
               next_st[uat_pkg::B_IN]                 = i_io_data[uat_pkg::B_IN];
               next_st[uat_pkg::B_DCH]                = i_io_data[uat_pkg::B_DCH];
               // translation pauses until the next indirect reference if the user bit is set, even if it was on
               next_st[uat_pkg::B_USR_ST] = 1'b0;
               next_usr_pend = i_io_data[uat_pkg::B_USR];
               next_pchk     = i_io_data;
            end
            uat_pkg::UAT_OP_READ_STATE: begin
               next_rd  = st;
               next_rdv = 1'b1;
            end
            uat_pkg::UAT_OP_PROBE_SELECT: begin
               next_pchk = i_io_data;
            end
            uat_pkg::UAT_OP_PROBE_READ: begin
               next_rd  = {pent[uat_pkg::B_FLAG], pchk[uat_pkg::SEL_LSB +: 3], 2'b00,
                           pent[uat_pkg::PAGE_W-1:0]};
               next_rdv = 1'b1;
            end
            uat_pkg::UAT_OP_PAGE31_SET: begin
               next_p31 = i_io_data[uat_pkg::PAGE_W-1:0];
            end
            uat_pkg::UAT_OP_SINGLE_REF_OR_OFF: begin
               if (!st[uat_pkg::B_USR_ST]) begin
                  next_single = 1'b1;
               end else if (!st[uat_pkg::B_LEF] && !st[uat_pkg::B_IO]) begin
                  next_st[uat_pkg::B_USR_ST] = 1'b0;
               end
            end
            uat_pkg::UAT_OP_BUS_RESET: begin
               next_st       = st & uat_pkg::RST_KEEP;
               next_st[uat_pkg::B_USR_ST] = 1'b0;
               next_p31      = uat_pkg::PAGE31_RST;
               next_usr_pend = 1'b0;
               next_single   = 1'b0;
            end
            default: begin
               next_rd = o_rd_data;
            end
         endcase
      end
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st           <= uat_pkg::ZERO_W;
         pchk         <= uat_pkg::ZERO_W;
         p31          <= uat_pkg::PAGE31_RST;
         usr_pend     <= 1'b0;
         single       <= 1'b0;
         o_rd_data    <= uat_pkg::ZERO_W;
         o_rd_valid   <= 1'b0;
         o_phys_addr  <= '0;
         o_fault      <= 1'b0;
         o_lef_exec   <= 1'b0;
         o_xlate_done <= 1'b0;
         o_int_hold   <= 1'b0;
      end else begin
         st           <= next_st;
         pchk         <= next_pchk;
         p31          <= next_p31;
         usr_pend     <= next_usr_pend;
         single       <= next_single;
         o_rd_data    <= next_rd;
         o_rd_valid   <= next_rdv;
         o_phys_addr  <= next_phys;
         o_fault      <= next_fault;
         o_lef_exec   <= next_lef;
         o_xlate_done <= next_done;
         o_int_hold   <= next_usr_pend | next_single;
      end
   end

   // bulk load: one word per memory answer; a zero count does nothing
   always_comb begin
      next_ld   = ld;
      next_cnt  = o_count_acc;
      next_ptr  = ptr;
      tbl_we    = 1'b0;
      unique case (ld)
         uat_pkg::UAT_LD_IDLE: begin
            if (i_lmp_start && (i_count_acc != uat_pkg::ZERO_W)) begin
               next_cnt = i_count_acc;
               next_ptr = i_pointer_acc;
               next_ld  = uat_pkg::UAT_LD_WAIT;
            end
         end
         uat_pkg::UAT_LD_WAIT: begin
            if (i_mem_valid) begin
               tbl_we   = 1'b1;
               next_cnt = o_count_acc - 16'h0001;
               next_ptr = ptr + 16'h0001;
               if (o_count_acc == 16'h0001) begin
                  next_ld = uat_pkg::UAT_LD_IDLE;
               end
            end
         end
      endcase
      next_mreq = (next_ld == uat_pkg::UAT_LD_WAIT);
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ld          <= uat_pkg::UAT_LD_IDLE;
         o_count_acc <= uat_pkg::ZERO_W;
         ptr         <= uat_pkg::ZERO_W;
         o_mem_addr  <= uat_pkg::ZERO_W;
         o_mem_req   <= 1'b0;
         o_load_busy <= 1'b0;
      end else begin
         ld          <= next_ld;
         o_count_acc <= next_cnt;
         ptr         <= next_ptr;
         o_mem_addr  <= next_ptr;
         o_mem_req   <= next_mreq;
         o_load_busy <= next_mreq;
      end
   end

   // tables are not reset: software loads them before enabling translation
   always_ff @(posedge i_core_clk) begin
      if (tbl_we) begin
         tables[st[uat_pkg::SEL_LSB +: 3]]
               [i_mem_data[uat_pkg::LPG_LSB +: uat_pkg::LPAGE_W]] <= i_mem_data;
      end
   end

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_reset_n);

   sequence seq_arm;
      usr_pend && i_ref_valid && i_ref.indirect && !cmd_hit;
   endsequence
   sequence seq_on;
      st[uat_pkg::B_USR_ST] ##0 !usr_pend;
   endsequence

   chk_user_start: assert property (seq_arm |=> seq_on)
      else $error("user translation not started after indirect");
   chk_page31_map: assert property (i_ref_valid && !i_ref.chan && !user_act
         && i_ref.addr[uat_pkg::WORD_W-1 -: uat_pkg::LPAGE_W] == uat_pkg::PAGE31
         |=> o_phys_addr[uat_pkg::PHYS_W-1 -: uat_pkg::PAGE_W] == $past(p31))
      else $error("page 31 not mapped through page31 register");
   chk_chan_invalid: assert property (i_ref_valid && i_ref.chan && st[uat_pkg::B_DCH]
         && ent[uat_pkg::B_FLAG] && (&ent[uat_pkg::PAGE_W-1:0]) |=> o_fault)
      else $error("invalid channel page not faulted");
   chk_write_fault: assert property (i_ref_valid && !i_ref.chan && user_act && i_ref.write
         && st[uat_pkg::B_WP] && ent[uat_pkg::B_FLAG]
         |=> o_fault ##1 (!o_fault || $past(i_ref_valid)))
      else $error("write protection fault missing or stuck");
   chk_lef_exec: assert property (i_ref_valid && !i_ref.chan && user_act
         && i_ref.io_instr && st[uat_pkg::B_LEF]
         |=> o_lef_exec && !(o_fault && st[uat_pkg::B_IOF]))
      else $error("io instruction not run as lef");
   chk_count_step: assert property (ld == uat_pkg::UAT_LD_WAIT && i_mem_valid
         |=> o_count_acc == $past(o_count_acc) - 16'h0001
             && o_mem_addr == $past(ptr) + 16'h0001)
      else $error("bulk load count or pointer step wrong");
   chk_ctrl_copy: assert property (cmd_hit && i_io_op == uat_pkg::UAT_OP_WRITE_CONTROL
         |=> pchk == $past(i_io_data)
             && st[uat_pkg::SEL_LSB +: 3] == $past(i_io_data[uat_pkg::SEL_LSB +: 3]))
      else $error("control word not copied");
   chk_bus_reset: assert property (cmd_hit && i_io_op == uat_pkg::UAT_OP_BUS_RESET
         |=> !st[uat_pkg::B_USR_ST] && p31 == uat_pkg::PAGE31_RST
             && (st & ~uat_pkg::RST_KEEP) == uat_pkg::ZERO_W)
      else $error("bus reset left state behind");
endmodule // uat_translator

// [common/uat_pkg.sv]
package uat_pkg;
   localparam int WORD_W  = 16;
   localparam int PAGE_W  = 10;
   localparam int LPAGE_W = 5;
   localparam int OFS_W   = 11;
   localparam int PHYS_W  = PAGE_W + OFS_W;
   localparam int NTBL    = 8;
   localparam int NENT    = 32;
   // bit positions, lsb-indexed (documented bit n is [15-n])
   localparam int B_MTE_HI = 15;
   localparam int B_USR_ST = 14;
   localparam int B_IOF    = 13;
   localparam int B_WPF    = 12;
   localparam int B_IDF    = 11;
   localparam int B_SC     = 10;
   localparam int SEL_LSB  = 7;
   localparam int B_LEF    = 6;
   localparam int B_IO     = 5;
   localparam int B_WP     = 4;
   localparam int B_IN     = 3;
   localparam int B_MTE_LO = 2;
   localparam int B_DCH    = 1;
   localparam int B_USR    = 0;
   localparam int B_UI     = 0;
   localparam int B_FLAG   = 15;
   localparam int LPG_LSB  = 10;
   localparam logic [5:0]        DEV_CODE   = 6'h03;
   localparam logic [4:0]        PAGE31     = 5'h1f;
   localparam logic [9:0]        PAGE31_RST = 10'h3ff;
   localparam logic [WORD_W-1:0] RST_KEEP   = 16'h4001;
   localparam logic [WORD_W-1:0] ZERO_W     = 16'h0000;
   typedef enum logic [2:0] {
      UAT_OP_WRITE_CONTROL, UAT_OP_READ_STATE, UAT_OP_PROBE_SELECT,
      UAT_OP_PROBE_READ, UAT_OP_PAGE31_SET, UAT_OP_SINGLE_REF_OR_OFF,
      UAT_OP_BUS_RESET
   } uat_op_t;
   typedef enum logic {UAT_LD_IDLE, UAT_LD_WAIT} uat_ld_t;
   typedef struct packed {
      logic              chan;
      logic [1:0]        chan_tbl;
      logic              write;
      logic              indirect;
      logic              io_instr;
      logic [WORD_W-1:0] addr;
   } uat_ref_t;
endpackage

// [bench/uat_mem_model.sv]
`timescale 1ns/1ps
// processor-side memory feeding bulk table loads, prompt or stalled
module uat_mem_model (
   input  wire logic        i_core_clk,
   input  wire logic        i_mem_req,
   input  wire logic [15:0] i_mem_addr,
   input  wire logic [3:0]  i_stall,
   output logic             o_mem_valid,
   output logic [15:0]      o_mem_data
);
   logic [15:0] mem [0:63];
   logic [3:0]  wait_cnt = 4'h0;
   initial o_mem_valid = 1'b0;
   initial o_mem_data = 16'h0000;
   always @(posedge i_core_clk) begin
      #1;
      if (i_mem_req === 1'b1 && wait_cnt >= i_stall) begin
         o_mem_valid = 1'b1;
         o_mem_data = mem[i_mem_addr[5:0]];
         wait_cnt = 4'h0;
      end else begin
         // idle data is inverted each cycle, so a stray strobe sees the stale word again after an even number of idle cycles
         o_mem_valid = 1'b0;
         o_mem_data = ~o_mem_data;
         if (i_mem_req === 1'b1) wait_cnt = wait_cnt + 4'h1;
      end
   end
endmodule // uat_mem_model

// [bench/tb.sv]
`timescale 1ns/1ps
module tb;
   localparam logic [5:0] W = 6'h04, IND = 6'h02, IO = 6'h01, CH = 6'h20;
   logic                   clk, rst_n, io_valid, ref_valid, int_taken, lmp_start, mv;
   logic [5:0]             io_dev;
   uat_pkg::uat_op_t       io_op;
   logic [15:0]            io_data, cnt, ptr, md, q, mem_addr, count_acc, rd_data;
   uat_pkg::uat_ref_t      rf;
   logic [3:0]             stall;
   logic [20:0]            phys;
   logic                   rd_valid, done, fault, effective_addr_mode, int_hold, mem_req, busy, lef_seen;
   int                     fail_count, n_checks, i;
   uat_translator u_uat_translator (.i_core_clk(clk), .i_reset_n(rst_n), .i_io_valid(io_valid),
      .i_io_dev(io_dev), .i_io_op(io_op), .i_io_data(io_data), .i_ref_valid(ref_valid),
      .i_ref(rf), .i_int_taken(int_taken), .i_lmp_start(lmp_start), .i_count_acc(cnt),
      .i_pointer_acc(ptr), .i_mem_valid(mv), .i_mem_data(md), .o_rd_data(rd_data),
      .o_rd_valid(rd_valid), .o_phys_addr(phys), .o_xlate_done(done), .o_fault(fault),
      .o_lef_exec(effective_addr_mode), .o_int_hold(int_hold), .o_mem_req(mem_req), .o_mem_addr(mem_addr),
      .o_count_acc(count_acc), .o_load_busy(busy));
   uat_mem_model u_uat_mem_model (.i_core_clk(clk), .i_mem_req(mem_req),
      .i_mem_addr(mem_addr), .i_stall(stall), .o_mem_valid(mv), .o_mem_data(md));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task end_of_test;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task cmd(input uat_pkg::uat_op_t op, input logic [15:0] d, input logic [5:0] dev);
      @(posedge clk);
      #1 io_valid = 1'b1;
      io_op = op;
      io_data = d;
      io_dev = dev;
      @(posedge clk);
      #1 io_valid = 1'b0;
      io_data = ~d;
   endtask
   task wr(input logic [15:0] d);
      cmd(uat_pkg::UAT_OP_WRITE_CONTROL, d, uat_pkg::DEV_CODE);
   endtask
   task rd(input uat_pkg::uat_op_t op);
      cmd(op, 16'h0000, uat_pkg::DEV_CODE);
      chk(rd_valid, 1);
      q = rd_data;
   endtask
   // status bit 0 mirrors the last interrupt, so most reads mask it out
   task rds(input logic [15:0] exp, input logic [15:0] m);
      rd(uat_pkg::UAT_OP_READ_STATE);
      chk(q & m, exp & m);
   endtask
   // a faulting reference carries no meaningful physical address
   task xref(input logic [5:0] f, input logic [15:0] a, input logic [20:0] ep,
             input logic ef);
      @(posedge clk);
      #1 ref_valid = 1'b1;
      rf = uat_pkg::uat_ref_t'({f, a});
      @(posedge clk);
      #1 ref_valid = 1'b0;
      chk(done, 1);
      chk(fault, ef);
      if (!ef) chk(phys, ep);
      lef_seen = effective_addr_mode;
   endtask
   task bulk_table_load(input logic [15:0] n, input logic [15:0] p);
      int k;
      @(posedge clk);
      #1 lmp_start = 1'b1;
      cnt = n;
      ptr = p;
      @(posedge clk);
      #1 lmp_start = 1'b0;
      k = 0;
      while (busy === 1'b1 && k < 100) begin
         @(posedge clk);
         #1 k++;
      end
      chk(busy, 0);
      chk(mem_req, 0);
      chk(count_acc, 0);
      chk(mem_addr, p + n);
   endtask
   initial begin
      #200000 fail_count++;
      end_of_test();
   end
   initial begin
      {rst_n, io_valid, ref_valid, int_taken, lmp_start} = 5'h00;
      {io_dev, io_data, cnt, ptr, rf, stall} = '0;
      io_op = uat_pkg::UAT_OP_READ_STATE;
      repeat (5) @(posedge clk);
      #1 rst_n = 1'b1;
      rds(16'h0000, 16'hffff);
      xref(0, 16'hf923, 21'h1ff923, 0);
      cmd(uat_pkg::UAT_OP_PAGE31_SET, 16'h0155, uat_pkg::DEV_CODE);
      xref(0, 16'hf923, 21'h0aa923, 0);
      cmd(uat_pkg::UAT_OP_WRITE_CONTROL, 16'hffff, 6'h04);
      rds(16'h0000, 16'hfffe);
      for (i = 0; i < 8; i++) begin
         wr(16'h0038 | (16'(i) << 7) | {i[1], 12'h000, i[0], 2'b00});
         rds(16'h0038 | (16'(i) << 7) | {i[1], 12'h000, i[0], 2'b00}, 16'hfffe);
      end
      wr(16'h0040);
      rds(16'h0000, 16'hfffe);
      u_uat_mem_model.mem[16] = 16'h0955;
      u_uat_mem_model.mem[17] = 16'h8eaa;
      u_uat_mem_model.mem[32] = 16'h93ff;
      u_uat_mem_model.mem[33] = 16'h1412;
      wr(16'h0000);
      stall = 4'h2;
      bulk_table_load(16'h0002, 16'h0010);
      cmd(uat_pkg::UAT_OP_PROBE_SELECT, 16'h0c00, uat_pkg::DEV_CODE);
      rd(uat_pkg::UAT_OP_PROBE_READ);
      chk(q, 16'h82aa);
      wr(16'h0202);
      rds(16'h0202, 16'hfffe);
      stall = 4'h0;
      bulk_table_load(16'h0002, 16'h0020);
      xref(CH, 16'h2000, 21'h0, 1);
      xref(CH, 16'h2807, 21'h009007, 0);
      wr(16'h0051);
      chk(int_hold, 1);
      xref(W, 16'h1010, 21'h001010, 0);
      xref(IND, 16'h1010, 21'h001010, 0);
      chk(int_hold, 0);
      xref(W, 16'h1010, 21'h0aa810, 0);
      xref(W, 16'h1810, 21'h0, 1);
      xref(IO, 16'h1010, 21'h0aa810, 0);
      chk(lef_seen, 1);
      rds(16'h5050, 16'hfffe);
      @(posedge clk);
      #1 int_taken = 1'b1;
      @(posedge clk);
      #1 int_taken = 1'b0;
      cmd(uat_pkg::UAT_OP_BUS_RESET, 16'h0000, uat_pkg::DEV_CODE);
      rds(16'h0001, 16'hffff);
      xref(0, 16'hf923, 21'h1ff923, 0);
      wr(16'h0029);
      xref(IND, 16'h1010, 21'h001010, 0);
      xref(IO, 16'h1010, 21'h0, 1);
      xref(IND, 16'h1010, 21'h0, 1);
      rds(16'h4828, 16'hfffe);
      wr(16'h0001);
      xref(IND, 16'h1010, 21'h001010, 0);
      cmd(uat_pkg::UAT_OP_SINGLE_REF_OR_OFF, 16'h0000, uat_pkg::DEV_CODE);
      rds(16'h0000, 16'h4000);
      cmd(uat_pkg::UAT_OP_SINGLE_REF_OR_OFF, 16'h0000, uat_pkg::DEV_CODE);
      chk(int_hold, 1);
      xref(0, 16'h1010, 21'h0aa810, 0);
      xref(0, 16'h1010, 21'h001010, 0);
      end_of_test();
   end
endmodule // tb
